/* File: src/irq_ctrl_pkg.sv */
package irq_ctrl_pkg;

  // ----------------------------------------------------------------
  // special function register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMER_AND_EXT_INT_CONTROL_ADDR = 8'h88;
  localparam logic [7:0] INT_ENABLE_2_ADDR = 8'h9A;
  localparam logic [7:0] INT_ENABLE_0_ADDR = 8'hA8;
  localparam logic [7:0] INT_ENABLE_1_ADDR = 8'hB8;
  localparam logic [7:0] EXT_INT_REQUEST_FLAGS_ADDR = 8'hC0;
  localparam logic [7:0] POL_ADDR = 8'hC8;
  localparam logic [7:0] SFLAG_A_ADDR = 8'hE8;
  localparam logic [7:0] SFLAG_B_ADDR = 8'hF8;

  // ----------------------------------------------------------------
  // extended memory offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] SEN_A_ADDR = 16'h2700;
  localparam logic [15:0] SEN_B_ADDR = 16'h2701;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GLOBAL_EN_BIT = 7;
  localparam int WDT_BIT = 6;
  localparam int SERIAL0_EN_BIT = 4;
  localparam int TIMER1_EN_BIT = 3;
  localparam int EXT1_EN_BIT = 2;
  localparam int TIMER0_EN_BIT = 1;
  localparam int EXT0_EN_BIT = 0;
  localparam int SERIAL1_EN_BIT = 0;
  localparam int EXT2_BIT = 1;
  localparam int EXT6_BIT = 5;
  localparam int TF1_BIT = 7;
  localparam int TR1_BIT = 6;
  localparam int TF0_BIT = 5;
  localparam int TR0_BIT = 4;
  localparam int IE1_BIT = 3;
  localparam int IT1_BIT = 2;
  localparam int IE0_BIT = 1;
  localparam int IT0_BIT = 0;
  localparam int POL3_BIT = 6;
  localparam int POL2_BIT = 5;
  // secondary flag and enable byte a share positions
  localparam int XFER_BIT = 0;
  localparam int SEC_BIT = 1;
  localparam int MIN_BIT = 2;
  localparam int TEMP_BIT = 4;
  localparam int YPULSE_BIT = 5;
  localparam int XPULSE_BIT = 6;
  localparam int EEX_BIT = 7;
  // byte b: spi flag and enable share bit 7; w and v flags and enables sit at different positions
  localparam int SPI_BIT = 7;
  localparam int WFLAG_BIT = 4;
  localparam int VFLAG_BIT = 3;
  localparam int WEN_BIT = 6;
  localparam int VEN_BIT = 5;
  localparam logic [7:0] SFLAG_A_MASK = 8'hF7;
  localparam logic [7:0] SFLAG_B_MASK = 8'h98;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // request vector order handed to the core
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SRC_EXT0, SRC_TIMER0, SRC_EXT1, SRC_TIMER1, SRC_SERIAL0, SRC_SERIAL1,
    SRC_EXT2, SRC_EXT3, SRC_EXT4, SRC_EXT5, SRC_EXT6
  } irq_src_t;
  localparam int IRQ_W = 11;

endpackage

/* File: src/sec_flag_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface sec_flag_if;
  logic [7:0] set_a;
  logic [7:0] set_b;
  logic wr_a;
  logic wr_b;
  logic [7:0] wdata;
  logic [7:0] flags_a;
  logic [7:0] flags_b;
  modport bank (input set_a, set_b, wr_a, wr_b, wdata, output flags_a, flags_b);
  modport ctrl (output set_a, set_b, wr_a, wr_b, wdata, input flags_a, flags_b);
endinterface
`default_nettype wire

/* File: src/irq_edge_detect.sv */
`timescale 1ns/100ps
`default_nettype none
module irq_edge_detect #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [W-1:0] sig,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] prev_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= sig;
    end
  end

  for (genvar i = 0; i < W; i++) begin : g_edge
    assign rise[i] = sig[i] & ~prev_reg[i];
    assign fall[i] = ~sig[i] & prev_reg[i];
  end
endmodule // irq_edge_detect
`default_nettype wire

/* File: src/sec_flag_bank.sv */
`timescale 1ns/100ps
`default_nettype none
module sec_flag_bank (
  input wire logic clk_sys,
  input wire logic arst_n,
  sec_flag_if.bank sf
);
  // ----------------------------------------------------------------
  // sticky flags, cleared only by a written zero
  // ----------------------------------------------------------------
  // a written one keeps the flag, so a byte mask clears just one bit;
  // an event in the clearing cycle wins over the clear
  logic [7:0] flags_a_reg;
  logic [7:0] flags_b_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flags_a_reg <= irq_ctrl_pkg::BYTE_RESET;
    end else begin
      flags_a_reg <= ((sf.wr_a ? (flags_a_reg & sf.wdata) : flags_a_reg) | sf.set_a)
                     & irq_ctrl_pkg::SFLAG_A_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flags_b_reg <= irq_ctrl_pkg::BYTE_RESET;
    end else begin
      flags_b_reg <= ((sf.wr_b ? (flags_b_reg & sf.wdata) : flags_b_reg) | sf.set_b)
                     & irq_ctrl_pkg::SFLAG_B_MASK;
    end
  end

  assign sf.flags_a = flags_a_reg;
  assign sf.flags_b = flags_b_reg;
endmodule // sec_flag_bank
`default_nettype wire

/* File: src/irq_request_ctrl.sv */
// How it works
// - global enable low blocks every request to the core
// - enable byte 0 gates serial0, timer1, ext1, timer0, ext0; bit 5 unused
// - enable byte 1 bits 1..5 gate external interrupts 2..6
// - enable byte 2 bit 0 gates serial channel 1
// - ext0/ext1 type bit: 0 low level, 1 falling edge
// - control byte holds timer and ext0/ext1 flags at bits 7,5,3,1
// - polarity bits 6 and 5 pick edge for ext3 and ext2
// - request byte shows pending ext2..6 at bits 1..5 until cleared
// - timer flags cleared by per-timer service acknowledge pulses
// - ext2 engine pulses, ext3 engine busy, ext4 supply state change
// - ext5 eeprom and spi, ext6 transfer and clock events
// - falling-edge sources of ext5/ext6 taken by fall detection on the raw, uninverted line
// - ext0..ext6 flags cleared when the core vectors to them
// - secondary flags cleared by writing zero, ones ignored
// - each secondary event has its own enable and flag
// - secondary enables in two extended bytes at fixed positions
// - secondary flags in two register bytes at fixed positions
// - ext0/ext1 taken from selectable digital pins
// - flags other than ext2, ext5, ext6 set whether or not the source is enabled
// - enabled pending request held to the core until vectored
`timescale 1ns/100ps
`default_nettype none
module irq_request_ctrl #(
  parameter int DIO_W = 16,
  parameter int SEL_W = 4
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [15:0] xram_addr,
  input wire logic xram_wr,
  input wire logic xram_rd,
  input wire logic [7:0] xram_wdata,
  output logic [7:0] xram_rdata,
  input wire logic [DIO_W-1:0] dio_in,
  input wire logic [SEL_W-1:0] ext0_pin_sel,
  input wire logic [SEL_W-1:0] ext1_pin_sel,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic timer0_service_ack,
  input wire logic timer1_service_ack,
  input wire logic serial0_request,
  input wire logic serial1_request,
  input wire logic [6:0] ext_vector_ack,
  input wire logic engine_x_pulse,
  input wire logic engine_y_pulse,
  input wire logic engine_w_pulse,
  input wire logic engine_v_pulse,
  input wire logic engine_busy,
  input wire logic [2:0] supply_state_field,
  input wire logic eeprom_busy,
  input wire logic spi_event,
  input wire logic transfer_busy_event,
  input wire logic clock_second_event,
  input wire logic clock_minute_event,
  input wire logic clock_temp_event,
  output logic [irq_ctrl_pkg::IRQ_W-1:0] irq_req
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] int_enable_0_reg;
  logic int_enable_2_reg;
  logic [6:2] int_enable_1_reg;
  logic [1:0] type_sel_reg;
  logic [1:0] run_reg;
  logic [1:0] polarity_reg;
  logic timer0_overflow_flag;
  logic timer1_overflow_flag;
  logic ext0_pending;
  logic ext1_pending;
  logic [6:2] ext_pending_reg;
  logic [7:0] sen_a_reg;
  logic [7:0] sen_b_reg;
  logic [irq_ctrl_pkg::IRQ_W-1:0] irq_req_reg;
  logic [7:0] sfr_rdata_reg;
  logic [7:0] xram_rdata_reg;
  logic [2:0] supply_prev_reg;

  logic wr_timer_and_ext_int_control;
  logic wr_ext_int_request_flags;
  logic ext0_pin;
  logic ext1_pin;
  logic [12:0] ev;
  logic [12:0] ev_rise;
  logic [12:0] ev_fall;
  logic [2:0] line;
  logic [2:0] line_rise;
  logic [2:0] line_fall;
  logic supply_change;
  logic global_int_enable;

  sec_flag_if sf ();

  sec_flag_bank u_bank (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .sf(sf.bank)
  );

  assign wr_timer_and_ext_int_control = sfr_wr && (sfr_addr == irq_ctrl_pkg::TIMER_AND_EXT_INT_CONTROL_ADDR);
  assign wr_ext_int_request_flags = sfr_wr && (sfr_addr == irq_ctrl_pkg::EXT_INT_REQUEST_FLAGS_ADDR);
  assign sf.wr_a = sfr_wr && (sfr_addr == irq_ctrl_pkg::SFLAG_A_ADDR);
  assign sf.wr_b = sfr_wr && (sfr_addr == irq_ctrl_pkg::SFLAG_B_ADDR);
  assign sf.wdata = sfr_wdata;
  assign global_int_enable = int_enable_0_reg[irq_ctrl_pkg::GLOBAL_EN_BIT];

  // ----------------------------------------------------------------
  // source conditioning
  // ----------------------------------------------------------------
  // the pin map is a plain selector; out-of-range selects read high (idle)
  function automatic logic pick_pin(input logic [DIO_W-1:0] pins,
                                    input logic [SEL_W-1:0] sel);
    pick_pin = (int'(sel) < DIO_W) ? pins[sel] : 1'b1;
  endfunction

  assign ext0_pin = pick_pin(dio_in, ext0_pin_sel);
  assign ext1_pin = pick_pin(dio_in, ext1_pin_sel);

  // busy lines end with a falling edge: it is taken by fall detection on the raw line,
  // whose previous sample resets low, so an idle-low busy line flags nothing after reset
  assign ev = {ext1_pin, ext0_pin, engine_v_pulse, engine_w_pulse, engine_x_pulse,
               engine_y_pulse, clock_temp_event, clock_minute_event,
               clock_second_event, spi_event, eeprom_busy, transfer_busy_event,
               engine_busy};

  irq_edge_detect #(.W(13)) u_ev_edge (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .sig(ev),
    .rise(ev_rise),
    .fall(ev_fall)
  );

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      supply_prev_reg <= 3'h0;
    end else begin
      supply_prev_reg <= supply_state_field;
    end
  end

  // the first sample after reset compares against zero on purpose
  assign supply_change = (supply_state_field != supply_prev_reg);

  // ----------------------------------------------------------------
  // secondary event flags
  // ----------------------------------------------------------------
  always_comb begin
    sf.set_a = 8'h00;
    sf.set_a[irq_ctrl_pkg::XFER_BIT] = ev_fall[1];
    sf.set_a[irq_ctrl_pkg::EEX_BIT] = ev_fall[2];
    sf.set_a[irq_ctrl_pkg::SEC_BIT] = ev_rise[4];
    sf.set_a[irq_ctrl_pkg::MIN_BIT] = ev_rise[5];
    sf.set_a[irq_ctrl_pkg::TEMP_BIT] = ev_rise[6];
    sf.set_a[irq_ctrl_pkg::YPULSE_BIT] = ev_rise[7];
    sf.set_a[irq_ctrl_pkg::XPULSE_BIT] = ev_rise[8];
  end

  always_comb begin
    sf.set_b = 8'h00;
    sf.set_b[irq_ctrl_pkg::SPI_BIT] = ev_rise[3];
    sf.set_b[irq_ctrl_pkg::WFLAG_BIT] = ev_rise[9];
    sf.set_b[irq_ctrl_pkg::VFLAG_BIT] = ev_rise[10];
  end

  // combined lines: 0 ext2 engine pulses, 1 ext5, 2 ext6
  assign line[0] = (sf.flags_a[irq_ctrl_pkg::XPULSE_BIT] & sen_a_reg[irq_ctrl_pkg::XPULSE_BIT])
                 | (sf.flags_a[irq_ctrl_pkg::YPULSE_BIT] & sen_a_reg[irq_ctrl_pkg::YPULSE_BIT])
                 | (sf.flags_b[irq_ctrl_pkg::WFLAG_BIT] & sen_b_reg[irq_ctrl_pkg::WEN_BIT])
                 | (sf.flags_b[irq_ctrl_pkg::VFLAG_BIT] & sen_b_reg[irq_ctrl_pkg::VEN_BIT]);
  assign line[1] = (sf.flags_a[irq_ctrl_pkg::EEX_BIT] & sen_a_reg[irq_ctrl_pkg::EEX_BIT])
                 | (sf.flags_b[irq_ctrl_pkg::SPI_BIT] & sen_b_reg[irq_ctrl_pkg::SPI_BIT]);
  assign line[2] = (sf.flags_a[irq_ctrl_pkg::XFER_BIT] & sen_a_reg[irq_ctrl_pkg::XFER_BIT])
                 | (sf.flags_a[irq_ctrl_pkg::SEC_BIT] & sen_a_reg[irq_ctrl_pkg::SEC_BIT])
                 | (sf.flags_a[irq_ctrl_pkg::MIN_BIT] & sen_a_reg[irq_ctrl_pkg::MIN_BIT])
                 | (sf.flags_a[irq_ctrl_pkg::TEMP_BIT] & sen_a_reg[irq_ctrl_pkg::TEMP_BIT]);

  irq_edge_detect #(.W(3)) u_line_edge (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .sig(line),
    .rise(line_rise),
    .fall(line_fall)
  );

  // ----------------------------------------------------------------
  // enable and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      int_enable_0_reg <= irq_ctrl_pkg::BYTE_RESET;
    end else if (sfr_wr && sfr_addr == irq_ctrl_pkg::INT_ENABLE_0_ADDR) begin
      int_enable_0_reg <= sfr_wdata & 8'hDF;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      int_enable_1_reg <= 5'h00;
    end else if (sfr_wr && sfr_addr == irq_ctrl_pkg::INT_ENABLE_1_ADDR) begin
      int_enable_1_reg <= sfr_wdata[irq_ctrl_pkg::EXT6_BIT:irq_ctrl_pkg::EXT2_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      int_enable_2_reg <= 1'b0;
    end else if (sfr_wr && sfr_addr == irq_ctrl_pkg::INT_ENABLE_2_ADDR) begin
      int_enable_2_reg <= sfr_wdata[irq_ctrl_pkg::SERIAL1_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      type_sel_reg <= 2'h0;
      run_reg <= 2'h0;
    end else if (wr_timer_and_ext_int_control) begin
      type_sel_reg <= {sfr_wdata[irq_ctrl_pkg::IT1_BIT], sfr_wdata[irq_ctrl_pkg::IT0_BIT]};
      run_reg <= {sfr_wdata[irq_ctrl_pkg::TR1_BIT], sfr_wdata[irq_ctrl_pkg::TR0_BIT]};
    end
  end

  // software is expected to leave both polarity bits at zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      polarity_reg <= 2'h0;
    end else if (sfr_wr && sfr_addr == irq_ctrl_pkg::POL_ADDR) begin
      polarity_reg <= {sfr_wdata[irq_ctrl_pkg::POL3_BIT], sfr_wdata[irq_ctrl_pkg::POL2_BIT]};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sen_a_reg <= irq_ctrl_pkg::BYTE_RESET;
      sen_b_reg <= irq_ctrl_pkg::BYTE_RESET;
    end else if (xram_wr) begin
      if (xram_addr == irq_ctrl_pkg::SEN_A_ADDR) begin
        sen_a_reg <= sfr_wdata_mask_a(xram_wdata);
      end
      if (xram_addr == irq_ctrl_pkg::SEN_B_ADDR) begin
        sen_b_reg <= xram_wdata & 8'hE0;
      end
    end
  end

  function automatic logic [7:0] sfr_wdata_mask_a(input logic [7:0] d);
    sfr_wdata_mask_a = d & irq_ctrl_pkg::SFLAG_A_MASK;
  endfunction

  // ----------------------------------------------------------------
  // request flags
  // ----------------------------------------------------------------
  // every flag: hardware set wins over any clear in the same cycle; all but
  // ext2, ext5 and ext6 set regardless of enables
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      timer0_overflow_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
    end else begin
      timer0_overflow_flag <= timer0_overflow | (~timer0_service_ack &
        (wr_timer_and_ext_int_control ? sfr_wdata[irq_ctrl_pkg::TF0_BIT] : timer0_overflow_flag));
      timer1_overflow_flag <= timer1_overflow | (~timer1_service_ack &
        (wr_timer_and_ext_int_control ? sfr_wdata[irq_ctrl_pkg::TF1_BIT] : timer1_overflow_flag));
    end
  end

  // level mode keeps setting the flag while the pin is low
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ext0_pending <= 1'b0;
      ext1_pending <= 1'b0;
    end else begin
      ext0_pending <= (type_sel_reg[0] ? ev_fall[11] : ~ext0_pin)
        | (~ext_vector_ack[0] &
           (wr_timer_and_ext_int_control ? sfr_wdata[irq_ctrl_pkg::IE0_BIT] : ext0_pending));
      ext1_pending <= (type_sel_reg[1] ? ev_fall[12] : ~ext1_pin)
        | (~ext_vector_ack[1] &
           (wr_timer_and_ext_int_control ? sfr_wdata[irq_ctrl_pkg::IE1_BIT] : ext1_pending));
    end
  end

  logic [6:2] ext_set;
  assign ext_set[2] = polarity_reg[0] ? line_rise[0] : line_fall[0];
  assign ext_set[3] = polarity_reg[1] ? ev_rise[0] : ev_fall[0];
  assign ext_set[4] = supply_change;
  assign ext_set[5] = line_rise[1];
  assign ext_set[6] = line_rise[2];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ext_pending_reg <= 5'h00;
    end else begin
      ext_pending_reg <= ext_set | (~ext_vector_ack[6:2] &
        (wr_ext_int_request_flags ? sfr_wdata[irq_ctrl_pkg::EXT6_BIT:irq_ctrl_pkg::EXT2_BIT]
                  : ext_pending_reg));
    end
  end

  // ----------------------------------------------------------------
  // requests to the core
  // ----------------------------------------------------------------
  // priority and in-service blocking live in the core; a request stays
  // up until its flag is cleared by vectoring
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_req_reg <= '0;
    end else begin
      irq_req_reg[irq_ctrl_pkg::SRC_EXT0] <= ext0_pending & int_enable_0_reg[irq_ctrl_pkg::EXT0_EN_BIT];
      irq_req_reg[irq_ctrl_pkg::SRC_TIMER0] <= timer0_overflow_flag
        & int_enable_0_reg[irq_ctrl_pkg::TIMER0_EN_BIT];
      irq_req_reg[irq_ctrl_pkg::SRC_EXT1] <= ext1_pending & int_enable_0_reg[irq_ctrl_pkg::EXT1_EN_BIT];
      irq_req_reg[irq_ctrl_pkg::SRC_TIMER1] <= timer1_overflow_flag
        & int_enable_0_reg[irq_ctrl_pkg::TIMER1_EN_BIT];
      irq_req_reg[irq_ctrl_pkg::SRC_SERIAL0] <= serial0_request
        & int_enable_0_reg[irq_ctrl_pkg::SERIAL0_EN_BIT];
      irq_req_reg[irq_ctrl_pkg::SRC_SERIAL1] <= serial1_request & int_enable_2_reg;
      irq_req_reg[irq_ctrl_pkg::SRC_EXT6:irq_ctrl_pkg::SRC_EXT2] <= ext_pending_reg & int_enable_1_reg;
      if (!global_int_enable) begin
        irq_req_reg <= '0;
      end
    end
  end

  assign irq_req = irq_req_reg;

  // ----------------------------------------------------------------
  // register read back
  // ----------------------------------------------------------------
  function automatic logic [7:0] sfr_read(input logic [7:0] a);
    case (a)
      irq_ctrl_pkg::TIMER_AND_EXT_INT_CONTROL_ADDR: sfr_read = {timer1_overflow_flag, run_reg[1],
                                           timer0_overflow_flag, run_reg[0], ext1_pending,
                                           type_sel_reg[1], ext0_pending, type_sel_reg[0]};
      irq_ctrl_pkg::INT_ENABLE_0_ADDR: sfr_read = int_enable_0_reg;
      irq_ctrl_pkg::INT_ENABLE_1_ADDR: sfr_read = {2'b00, int_enable_1_reg, 1'b0};
      irq_ctrl_pkg::INT_ENABLE_2_ADDR: sfr_read = {7'h00, int_enable_2_reg};
      irq_ctrl_pkg::EXT_INT_REQUEST_FLAGS_ADDR: sfr_read = {2'b00, ext_pending_reg, 1'b0};
      irq_ctrl_pkg::POL_ADDR: sfr_read = {1'b0, polarity_reg, 5'h00};
      irq_ctrl_pkg::SFLAG_A_ADDR: sfr_read = sf.flags_a;
      irq_ctrl_pkg::SFLAG_B_ADDR: sfr_read = sf.flags_b;
      default: sfr_read = 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata_reg <= irq_ctrl_pkg::BYTE_RESET;
    end else if (sfr_rd) begin
      sfr_rdata_reg <= sfr_read(sfr_addr);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      xram_rdata_reg <= irq_ctrl_pkg::BYTE_RESET;
    end else if (xram_rd) begin
      if (xram_addr == irq_ctrl_pkg::SEN_A_ADDR) begin
        xram_rdata_reg <= sen_a_reg;
      end else if (xram_addr == irq_ctrl_pkg::SEN_B_ADDR) begin
        xram_rdata_reg <= sen_b_reg;
      end else begin
        xram_rdata_reg <= 8'h00;
      end
    end
  end

  assign sfr_rdata = sfr_rdata_reg;
  assign xram_rdata = xram_rdata_reg;
endmodule // irq_request_ctrl
`default_nettype wire

/* File: dv/irq_request_ctrl_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module irq_request_ctrl_asserts (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic [15:0] xram_addr,
  input wire logic xram_rd,
  input wire logic [7:0] xram_rdata,
  input wire logic timer0_overflow,
  input wire logic timer0_service_ack,
  input wire logic [6:0] ext_vector_ack,
  input wire logic [2:0] supply_state_field,
  input wire logic [irq_ctrl_pkg::IRQ_W-1:0] irq_req
);
  // ----
  // shadow of enable byte 0, rebuilt from the write strobes
  // ----
  logic [7:0] en0_reg;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      en0_reg <= 8'h00;
    end else if (sfr_wr && sfr_addr == irq_ctrl_pkg::INT_ENABLE_0_ADDR) begin
      en0_reg <= sfr_wdata;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_global_off_blocks: assert property (!en0_reg[7] |=> irq_req == '0)
    else $error("request with global enable off");
  a_enable_gates_req: assert property (irq_req[1] |-> $past(en0_reg[1]))
    else $error("timer0 request while disabled");
  a_timer0_sets_req: assert property (
    timer0_overflow && en0_reg[7] && en0_reg[1] |-> ##2 irq_req[1])
    else $error("timer0 overflow not requested");
  a_timer0_ack_clears: assert property (
    timer0_service_ack && !timer0_overflow |-> ##2 !irq_req[1])
    else $error("timer0 request survives ack");
  a_vector_clears_ext4: assert property (
    ext_vector_ack[4] && $stable(supply_state_field) |-> ##2 !irq_req[8])
    else $error("ext4 request survives vector");
  a_pol_reserved_zero: assert property (
    sfr_rd && sfr_addr == irq_ctrl_pkg::POL_ADDR |=> !sfr_rdata[7] && sfr_rdata[4:0] == 5'h00)
    else $error("polarity unused bits not zero");
  a_ext_int_request_flags_reserved_zero: assert property (
    sfr_rd && sfr_addr == irq_ctrl_pkg::EXT_INT_REQUEST_FLAGS_ADDR |=> sfr_rdata[7:6] == 2'h0 && !sfr_rdata[0])
    else $error("request byte unused bits not zero");
  a_xram_unmapped_zero: assert property (
    xram_rd && xram_addr != irq_ctrl_pkg::SEN_A_ADDR && xram_addr != irq_ctrl_pkg::SEN_B_ADDR
    |=> xram_rdata == 8'h00)
    else $error("unmapped extended read not zero");
endmodule // irq_request_ctrl_asserts
bind irq_request_ctrl irq_request_ctrl_asserts u_chk (.clk_sys, .arst_n, .sfr_addr, .sfr_wr,
  .sfr_rd, .sfr_wdata, .sfr_rdata, .xram_addr, .xram_rd, .xram_rdata, .timer0_overflow,
  .timer0_service_ack, .ext_vector_ack, .supply_state_field, .irq_req);
`default_nettype wire

/* File: dv/core_model.sv */
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic stall,
  input wire logic [irq_ctrl_pkg::IRQ_W-1:0] irq_req,
  output logic timer0_service_ack,
  output logic timer1_service_ack,
  output logic [6:0] ext_vector_ack
);
  // stall stands for a handler of equal or higher priority in service
  logic [irq_ctrl_pkg::IRQ_W-1:0] ack_reg;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg <= '0;
    end else begin
      ack_reg <= stall ? '0 : irq_req & ~ack_reg;
    end
  end
  assign timer0_service_ack = ack_reg[1];
  assign timer1_service_ack = ack_reg[3];
  assign ext_vector_ack = {ack_reg[10:6], ack_reg[2], ack_reg[0]};
endmodule // core_model
`default_nettype wire

/* File: dv/mpu_interrupt_request_control_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module mpu_interrupt_request_control_tb_top;
  logic clk_sys, arst_n, sfr_wr, sfr_rd, xram_wr, xram_rd, stall, t0_ack, t1_ack, ovf, pulse;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xram_rdata;
  logic [15:0] xram_addr, dio;
  logic [6:0] vec_ack;
  logic [2:0] supply;
  logic [irq_ctrl_pkg::IRQ_W-1:0] irq_req;
  int err_total, checks;
  logic [15:0] addr_t [8] = '{16'hA8, 16'hB8, 16'h9A, 16'hC8, 16'hE8, 16'h2700, 16'h2701, 16'h2702};
  logic [7:0] exp_t [8] = '{8'hDF, 8'h3E, 8'h01, 8'h60, 8'h00, 8'hF7, 8'hE0, 8'h00};
  // one event line feeds several sources so each flag position except transfer and eeprom shows at once
  irq_request_ctrl dut (.clk_sys, .arst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .xram_addr, .xram_wr, .xram_rd, .xram_wdata(sfr_wdata), .xram_rdata, .dio_in(dio),
    .ext0_pin_sel(4'h0), .ext1_pin_sel(4'h1), .timer0_overflow(ovf), .timer1_overflow(ovf),
    .timer0_service_ack(t0_ack), .timer1_service_ack(t1_ack), .serial0_request(ovf),
    .serial1_request(ovf), .ext_vector_ack(vec_ack), .engine_x_pulse(pulse),
    .engine_y_pulse(pulse), .engine_w_pulse(pulse), .engine_v_pulse(pulse),
    .engine_busy(1'b0), .supply_state_field(supply), .eeprom_busy(1'b0), .spi_event(pulse),
    .transfer_busy_event(1'b0), .clock_second_event(pulse), .clock_minute_event(pulse),
    .clock_temp_event(pulse), .irq_req);
  core_model core (.clk_sys, .arst_n, .stall, .irq_req, .timer0_service_ack(t0_ack),
    .timer1_service_ack(t1_ack), .ext_vector_ack(vec_ack));
  // ----
  // access tasks
  // ----
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    sfr_addr = a[7:0];
    xram_addr = a;
    sfr_wdata = d;
    {sfr_wr, xram_wr} = {w && a[15:8] == 8'h00, w && a[15:8] != 8'h00};
    {sfr_rd, xram_rd} = {!w && a[15:8] == 8'h00, !w && a[15:8] != 8'h00};
    @(negedge clk_sys);
    {sfr_wr, sfr_rd, xram_wr, xram_rd} = 4'h0;
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk({8'h00, a[15:8] == 8'h00 ? sfr_rdata : xram_rdata}, {8'h00, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    #1000000;
    err_total++;
    report_and_stop();
  end
  // ----
  // scenarios
  // ----
  initial begin
    {arst_n, sfr_wr, sfr_rd, xram_wr, xram_rd, ovf, pulse, stall} = 8'h01;
    {sfr_addr, sfr_wdata, xram_addr, supply, dio} = {32'h0, 3'h0, 16'hFFFF};
    cyc(8);
    arst_n = 1'b1;
    cyc(2);
    for (int i = 0; i < 8; i++) begin
      rd(addr_t[i], 8'h00);
      acc(1'b1, addr_t[i], 8'hFF);
      rd(addr_t[i], exp_t[i]);
      acc(1'b1, addr_t[i], 8'h00);
    end
    acc(1'b1, 16'hA8, 8'h02);
    ovf = 1'b1;
    cyc(1);
    ovf = 1'b0;
    cyc(3);
    chk(16'(irq_req), 16'h0000);
    rd(16'h88, 8'hA0);
    acc(1'b1, 16'hA8, 8'h82);
    chk(16'(irq_req), 16'h0002);
    stall = 1'b0;
    cyc(4);
    rd(16'h88, 8'h80);
    ovf = 1'b1;
    cyc(1);
    ovf = 1'b0;
    cyc(4);
    stall = 1'b1;
    acc(1'b1, 16'hB8, 8'h08);
    supply = 3'h5;
    cyc(4);
    chk(16'(irq_req), 16'h0100);
    rd(16'hC0, 8'h08);
    stall = 1'b0;
    cyc(4);
    rd(16'hC0, 8'h00);
    stall = 1'b1;
    acc(1'b1, 16'hC8, 8'h20);
    acc(1'b1, 16'h2700, 8'h40);
    acc(1'b1, 16'hB8, 8'h02);
    pulse = 1'b1;
    cyc(6);
    chk(16'(irq_req), 16'h0040);
    rd(16'hE8, 8'h76);
    rd(16'hF8, 8'h98);
    acc(1'b1, 16'hE8, 8'hFF);
    rd(16'hE8, 8'h76);
    acc(1'b1, 16'hE8, 8'hBF);
    rd(16'hE8, 8'h36);
    rd(16'hC0, 8'h02);
    acc(1'b1, 16'hC8, 8'h00);
    acc(1'b1, 16'hA8, 8'h81);
    dio = 16'hFFFE;
    cyc(3);
    chk(16'(irq_req), 16'h0041);
    rd(16'h88, 8'h82);
    acc(1'b1, 16'h88, 8'h81);
    rd(16'h88, 8'h83);
    acc(1'b1, 16'h88, 8'h81);
    rd(16'h88, 8'h81);
    report_and_stop();
  end
endmodule // mpu_interrupt_request_control_tb_top
`default_nettype wire
